// ### bmrc_pkg.sv
// package of constants and types for the boot mode reset control block
// ------------------------------------------------------------------
// Overview of operation
// [R1] releasing reset with the strap pin high starts fetching from internal flash in single chip mode.
// [R2] releasing reset with the strap pin low starts execution from the boot rom in single boot mode.
// [R3] the mode depends only on the strap level held during reset and is sampled at reset release.
// [R4] the board must hold reset low for at least twelve system clocks with supply and oscillator stable.
// [R5] every reset returns the clock gear to the undivided one to one setting.
// [R6] at power on the board must hold reset low for at least seven hundred microseconds.
// [R7] reset during a flash program or erase must stay low for at least half a microsecond.
// [R8] after a reset that cut a flash program or erase, flash reads stay blocked for about two ms.
// [R9] flash contents are never returned to reads while flash is erasing or writing; here flash_read_en falls one clock after flash_busy rises.
// [R10] software keeps all interrupts, the non maskable one included, off while in user boot mode.
// [R11] every reset puts the flash back into normal read mode and ends user boot programming.
// [R12] in single boot mode the boot rom sits at address zero and flash moves to a higher base.
// [R13] the strap level is synchronised and the latched mode holds until the next reset.
// [R14] reset low time is counted in clocks and pulses shorter than the minimum are ignored.
// ------------------------------------------------------------------
package bmrc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int RST_MIN_CYC = 12;
  localparam int BUSY_RST_NS = 500;
  localparam int BUSY_RST_CYC_RAW = (BUSY_RST_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BUSY_RST_CYC = (BUSY_RST_CYC_RAW < 1) ? 1 : BUSY_RST_CYC_RAW;
  localparam int POR_US = 700;
  localparam int POR_CYC = POR_US * (CLK_HZ / 1000000);
  localparam int RECOV_US = 2000;
  localparam int RECOV_CYC = RECOV_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 24;
  localparam logic [31:0] FLASH_BASE_NORMAL = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE_BOOT = 32'h3F80_0000;
  localparam logic [31:0] BOOTROM_BASE = 32'h0000_0000;
  localparam logic [1:0] GEAR_DIV1 = 2'h0;
  localparam logic STRAP_CHIP = 1'b1;
  typedef enum logic [1:0] {BMRC_IN_RESET, BMRC_RECOVER, BMRC_RUN} bmrc_state_t;
endpackage : bmrc_pkg

// ### bmrc_sync.sv
// two flop synchroniser for board level inputs
`timescale 1ns/1ps
module bmrc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s1_nxt;
  logic q_r;
  logic q_nxt;
  always_comb begin
    s1_nxt = d;
    q_nxt = s1_r;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= INIT;
      q_r <= INIT;
    end else begin
      s1_r <= s1_nxt;
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule : bmrc_sync

// ### bmrc_top.sv
// boot mode selection, reset filtering and flash read gating
`timescale 1ns/1ps
module bmrc_top
  import bmrc_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int RECOV_CYCLES = RECOV_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic strap_port_bit,
  input wire logic flash_busy,
  input wire logic user_boot_req,
  output logic core_rst,
  output logic single_boot,
  output logic single_chip,
  output logic flash_read_en,
  output logic flash_normal_mode,
  output logic user_boot_active,
  output logic [1:0] clock_gear,
  output logic [31:0] flash_base,
  output logic [31:0] bootrom_base
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic rstn_s;
  logic strap_s;
  bmrc_sync #(.INIT(1'b0)) u_sync_rst (
    .clk(clk), .rst(rst), .d(reset_pin_n), .q(rstn_s)
  );
  // [R13] strap synchronised
  bmrc_sync #(.INIT(1'b1)) u_sync_strap (
    .clk(clk), .rst(rst), .d(strap_port_bit), .q(strap_s)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  bmrc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] low_cnt_r, low_cnt_nxt;
  logic [CNT_W-1:0] rec_cnt_r, rec_cnt_nxt;
  logic por_r, por_nxt;
  logic busy_seen_r, busy_seen_nxt;
  logic strap_r, strap_nxt;
  logic boot_r, boot_nxt;
  logic ub_r, ub_nxt;
  logic rd_en_r, rd_en_nxt;
  logic core_rst_r, core_rst_nxt;
  logic chip_r, chip_nxt;
  logic fnm_r, fnm_nxt;
  logic [CNT_W-1:0] need;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction : cyc

  always_comb begin
    // power on reset needs the long low time, busy reset the half microsecond
    need = cyc(RST_MIN_CYC);
    if (por_r && cyc(POR_CYCLES) > need) need = cyc(POR_CYCLES);
    if (busy_seen_r && cyc(BUSY_RST_CYC) > need) need = cyc(BUSY_RST_CYC);
    state_nxt = state_r;
    low_cnt_nxt = low_cnt_r;
    rec_cnt_nxt = rec_cnt_r;
    por_nxt = por_r;
    busy_seen_nxt = busy_seen_r;
    strap_nxt = strap_r;
    boot_nxt = boot_r;
    ub_nxt = ub_r;
    rd_en_nxt = rd_en_r;
    core_rst_nxt = core_rst_r;
    case (state_r)
      BMRC_IN_RESET: begin
        // [R3] strap tracked during reset
        strap_nxt = strap_s;
        if (!rstn_s) begin
          if (low_cnt_r != {CNT_W{1'b1}}) low_cnt_nxt = low_cnt_r + 1'b1;
          // [R14] core held only once the minimum is met
          if (low_cnt_nxt >= need) begin
            core_rst_nxt = 1'b1;
            rd_en_nxt = 1'b0;
            // [R11] flash back to normal mode
            ub_nxt = 1'b0;
          end else if (!por_r && !busy_seen_r) begin
            // a pulse that may still be rejected leaves reads running
            rd_en_nxt = !flash_busy;
          end
        end else if (low_cnt_r >= need) begin
          // [R1] [R2] mode chosen at release
          boot_nxt = (strap_r != STRAP_CHIP);
          por_nxt = 1'b0;
          low_cnt_nxt = '0;
          core_rst_nxt = 1'b0;
          rec_cnt_nxt = '0;
          if (busy_seen_r) begin
            rd_en_nxt = 1'b0;
            state_nxt = BMRC_RECOVER;
          end else begin
            // [R9] reads stay shut if flash is still busy
            rd_en_nxt = !flash_busy;
            state_nxt = BMRC_RUN;
          end
          busy_seen_nxt = 1'b0;
        end else begin
          // [R14] short pulse ignored
          low_cnt_nxt = '0;
          core_rst_nxt = (state_r == BMRC_IN_RESET) && por_r;
          if (!por_r) begin
            state_nxt = BMRC_RUN;
            rd_en_nxt = !flash_busy;
            busy_seen_nxt = 1'b0;
          end
        end
      end
      BMRC_RECOVER: begin
        // [R8] reads held off after interrupted program
        rec_cnt_nxt = rec_cnt_r + 1'b1;
        if (rec_cnt_r >= cyc(RECOV_CYCLES) - 1'b1) begin
          rd_en_nxt = !flash_busy;
          busy_seen_nxt = 1'b0;
          state_nxt = BMRC_RUN;
        end
        if (!rstn_s) begin
          busy_seen_nxt = 1'b1;
          state_nxt = BMRC_IN_RESET;
          low_cnt_nxt = cyc(1);
        end
      end
      default: begin
        // [R9] reads shut one clock after erase or write begins
        rd_en_nxt = !flash_busy;
        if (user_boot_req && !boot_r) ub_nxt = 1'b1;
        if (!rstn_s) begin
          // [R13] mode held until this reset
          busy_seen_nxt = flash_busy;
          low_cnt_nxt = cyc(1);
          state_nxt = BMRC_IN_RESET;
        end
      end
    endcase
    // inverse outputs get their own flops so every port is registered
    chip_nxt = !boot_nxt;
    fnm_nxt = !ub_nxt;
  end

  // a short glitch in run keeps the core running, so leaving reset state on a
  // rejected pulse returns to run without touching the latched mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= BMRC_IN_RESET;
      low_cnt_r <= '0;
      rec_cnt_r <= '0;
      por_r <= 1'b1;
      busy_seen_r <= 1'b0;
      strap_r <= STRAP_CHIP;
      boot_r <= 1'b0;
      ub_r <= 1'b0;
      rd_en_r <= 1'b0;
      core_rst_r <= 1'b1;
      chip_r <= 1'b1;
      fnm_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      low_cnt_r <= low_cnt_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      por_r <= por_nxt;
      busy_seen_r <= busy_seen_nxt;
      strap_r <= strap_nxt;
      boot_r <= boot_nxt;
      ub_r <= ub_nxt;
      rd_en_r <= rd_en_nxt;
      core_rst_r <= core_rst_nxt;
      chip_r <= chip_nxt;
      fnm_r <= fnm_nxt;
    end
  end

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  logic [1:0] gear_r;
  logic [31:0] fbase_r;
  logic [31:0] rbase_r;
  logic [1:0] gear_nxt;
  logic [31:0] fbase_nxt;
  logic [31:0] rbase_nxt;
  always_comb begin
    // [R5] gear undivided after reset
    gear_nxt = GEAR_DIV1;
    // [R12] flash relocated in single boot
    fbase_nxt = boot_r ? FLASH_BASE_BOOT : FLASH_BASE_NORMAL;
    rbase_nxt = BOOTROM_BASE;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gear_r <= GEAR_DIV1;
      fbase_r <= FLASH_BASE_NORMAL;
      rbase_r <= BOOTROM_BASE;
    end else begin
      gear_r <= gear_nxt;
      fbase_r <= fbase_nxt;
      rbase_r <= rbase_nxt;
    end
  end

  assign core_rst = core_rst_r;
  assign single_boot = boot_r;
  assign single_chip = chip_r;
  assign flash_read_en = rd_en_r;
  assign flash_normal_mode = fnm_r;
  assign user_boot_active = ub_r;
  assign clock_gear = gear_r;
  assign flash_base = fbase_r;
  assign bootrom_base = rbase_r;
endmodule : bmrc_top

// ### bmrc_assertions.sv
// port checker for the boot mode reset control block
`timescale 1ns/1ps
module bmrc_assertions
  import bmrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic strap_port_bit,
  input wire logic flash_busy,
  input wire logic core_rst,
  input wire logic single_boot,
  input wire logic single_chip,
  input wire logic flash_read_en,
  input wire logic flash_normal_mode,
  input wire logic user_boot_active,
  input wire logic [1:0] clock_gear,
  input wire logic [31:0] flash_base,
  input wire logic [31:0] bootrom_base
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_release;
    $fell(core_rst);
  endsequence
  // base register trails the mode by one cycle, so mode must be held
  sequence s_boot_held;
    single_boot [*2];
  endsequence
  sequence s_chip_held;
    single_chip [*2];
  endsequence
  a_mode_strap: assert property (
    s_release |-> single_boot != $past(strap_port_bit, 4))
    else $error("mode does not match strap");
  a_mode_hold: assert property (
    $changed(single_boot) |-> $fell(core_rst))
    else $error("mode changed outside release");
  a_chip_flash: assert property (
    s_chip_held |-> flash_base == FLASH_BASE_NORMAL)
    else $error("flash base wrong in chip mode");
  a_boot_flash: assert property (
    s_boot_held |-> flash_base == FLASH_BASE_BOOT)
    else $error("flash base wrong in boot mode");
  a_chip_inv: assert property (
    single_chip != single_boot)
    else $error("mode outputs disagree");
  a_rom_base: assert property (
    bootrom_base == BOOTROM_BASE)
    else $error("boot rom base wrong");
  a_gear_div1: assert property (
    clock_gear == GEAR_DIV1)
    else $error("clock gear not undivided");
  a_busy_block: assert property (
    flash_busy |=> !flash_read_en)
    else $error("flash read open while busy");
  a_reset_norm: assert property (
    core_rst [*2] |-> flash_normal_mode && !user_boot_active)
    else $error("user boot state kept in reset");
endmodule : bmrc_assertions

// ### bmrc_board.sv
// board model driving the reset pin and the boot strap
`timescale 1ns/1ps
module bmrc_board (
  input wire logic clk,
  output logic reset_pin_n,
  output logic strap_port_bit
);
  initial begin
    reset_pin_n = 1'b0;
    strap_port_bit = 1'b1;
  end
  task automatic pulse(input int n, input logic s);
    @(posedge clk) reset_pin_n <= 1'b0;
    strap_port_bit <= s;
    repeat (n) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask : pulse
endmodule : bmrc_board

// ### tb_top.sv
// self-checking bench for the boot mode reset control block
`timescale 1ns/1ps
module tb_top;
  import bmrc_pkg::*;
  logic clk, rst, busy, ub_req, pin_n, strap, core_rst, sb, sc, rd_en, fnm, uba;
  logic [1:0] gear;
  logic [31:0] fbase, rbase;
  int err_total, compares;
  // rows: strap level and low time, mode follows strap
  logic row_s [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int row_n [4] = '{12, 14, 30, 12};
  bmrc_board i_brd (.clk, .reset_pin_n(pin_n), .strap_port_bit(strap));
  bmrc_top #(.POR_CYCLES(50), .RECOV_CYCLES(30)) i_dut (.clk, .rst,
    .reset_pin_n(pin_n), .strap_port_bit(strap), .flash_busy(busy),
    .user_boot_req(ub_req), .core_rst, .single_boot(sb), .single_chip(sc),
    .flash_read_en(rd_en), .flash_normal_mode(fnm),
    .user_boot_active(uba), .clock_gear(gear), .flash_base(fbase),
    .bootrom_base(rbase));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic mode_chk(input logic s);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(32'(core_rst), 32'h0);
    chk(32'(sb), 32'(!s));
    chk(32'(sc), 32'(s));
    chk(fbase, s ? FLASH_BASE_NORMAL : FLASH_BASE_BOOT);
  endtask : mode_chk
  task automatic wrap_up;
    $display("compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    ub_req = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    i_brd.pulse(60, 1'b1);
    mode_chk(1'b1);
    $display("power on done");
    for (int i = 0; i < 4; i++) begin
      i_brd.pulse(row_n[i], row_s[i]);
      mode_chk(row_s[i]);
      chk(32'(rd_en), 32'h1);
      $display("row %0d done", i);
    end
    // too short a pulse must leave core, mode and strap change unseen
    fork
      i_brd.pulse(5, 1'b0);
      begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk(32'(core_rst), 32'h0);
      end
    join
    mode_chk(1'b1);
    $display("short pulse done");
    // user boot entered with no interrupt source driven
    @(posedge clk) ub_req <= 1'b1;
    @(posedge clk) ub_req <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(uba), 32'h1);
    chk(32'(fnm), 32'h0);
    @(posedge clk) busy <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(rd_en), 32'h0);
    i_brd.pulse(22, 1'b1);
    busy <= 1'b0;
    mode_chk(1'b1);
    chk(32'(uba), 32'h0);
    chk(32'(fnm), 32'h1);
    chk(32'(rd_en), 32'h0);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(32'(rd_en), 32'h1);
    $display("busy reset done");
    wrap_up();
  end
endmodule : tb_top
bind bmrc_top bmrc_assertions i_chk (.clk, .rst, .strap_port_bit,
  .flash_busy, .core_rst, .single_boot, .single_chip, .flash_read_en,
  .flash_normal_mode, .user_boot_active, .clock_gear, .flash_base,
  .bootrom_base);
